// ===== frc_pkg.sv
// Shared constants, types and helpers for the bus-matching FIFO block
package frc_pkg;

	localparam int unsigned DATA_W = 18;
	localparam int unsigned BYTE_W = 9;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned DEPTH  = 512;
	localparam int unsigned CNT_W  = 10;
	localparam int unsigned OFS_W  = 9;

	localparam logic [CNT_W-1:0]  CNT_ZERO   = 10'h000;
	localparam logic [CNT_W-1:0]  CNT_ONE    = 10'h001;
	localparam logic [CNT_W-1:0]  HALF_LEVEL = 10'h100;
	localparam logic [CNT_W-1:0]  DEPTH_CNT  = 10'h200;
	localparam logic [ADDR_W-1:0] PTR_ZERO   = 9'h000;
	localparam logic [ADDR_W-1:0] PTR_ONE    = 9'h001;
	localparam logic [DATA_W-1:0] WORD_ZERO  = 18'h00000;
	localparam logic [BYTE_W-1:0] BYTE_ZERO  = 9'h000;
	localparam logic [OFS_W-1:0]  OFS_RST    = 9'h07f;

	// Preset almost-empty/almost-full offsets, one per strap combination
	localparam logic [OFS_W-1:0] OFS_PRESET0 = 9'h07f;
	localparam logic [OFS_W-1:0] OFS_PRESET1 = 9'h00f;
	localparam logic [OFS_W-1:0] OFS_PRESET2 = 9'h01f;
	localparam logic [OFS_W-1:0] OFS_PRESET3 = 9'h03f;
	localparam logic [OFS_W-1:0] OFS_PRESET4 = 9'h007;
	localparam logic [OFS_W-1:0] OFS_PRESET5 = 9'h0ff;
	localparam logic [OFS_W-1:0] OFS_PRESET6 = 9'h001;
	localparam logic [OFS_W-1:0] OFS_PRESET7 = 9'h003;

	typedef enum logic {
		FRC_OFS_EMPTY = 1'b0,
		FRC_OFS_FULL  = 1'b1
	} frc_ofs_sel_t;

	typedef struct packed {
		logic       fallthrough_mode;
		logic       little_endian;
		logic       write_narrow;
		logic       read_narrow;
		logic       parity_interspersed;
		logic       serial_method;
		logic [2:0] default_idx;
	} frc_cfg_t;

	localparam frc_cfg_t CFG_RST = 9'h000;

	function automatic logic [OFS_W-1:0] frc_default_ofs(input logic [2:0] idx);
		logic [OFS_W-1:0] v;
		v = OFS_PRESET0;
		unique case (idx)
			3'h0: v = OFS_PRESET0;
			3'h1: v = OFS_PRESET1;
			3'h2: v = OFS_PRESET2;
			3'h3: v = OFS_PRESET3;
			3'h4: v = OFS_PRESET4;
			3'h5: v = OFS_PRESET5;
			3'h6: v = OFS_PRESET6;
			3'h7: v = OFS_PRESET7;
		endcase
		return v;
	endfunction

	// Parity bit 8 is skipped only for an x18 port in interspersed mode
	function automatic logic [OFS_W-1:0] frc_parallel_ofs(input logic [DATA_W-1:0] d, input logic interspersed,
		input logic narrow);
		logic [OFS_W-1:0] v;
		v = d[8:0];
		if (interspersed && !narrow) begin
			v = {d[9], d[7:0]};
		end
		return v;
	endfunction

	function automatic logic [BYTE_W-1:0] frc_pick_byte(input logic [DATA_W-1:0] w, input logic upper);
		return upper ? w[17:9] : w[8:0];
	endfunction

endpackage

// ===== frc_cfg_if.sv
// Configuration captured at full reset, passed to the FIFO core
`timescale 1ns/1ps
interface frc_cfg_if;
	import frc_pkg::*;

	frc_cfg_t cfg;   // Latched straps
	logic     in_rst; // Full reset active

	modport src (output cfg, output in_rst);
	modport dst (input cfg, input in_rst);
endinterface

// ===== frc_cfg_capture.sv
// Strap capture during full reset
`timescale 1ns/1ps
module frc_cfg_capture
	import frc_pkg::*;
(
	input  wire logic clk_sys,                  // System clock
	input  wire logic rst_n,                    // Sync reset, active low
	input  wire logic full_reset_n,             // Full reset pin, active low
	input  wire logic fallthrough_or_serial_in, // Timing-mode strap
	input  wire logic byte_order_sel,           // Byte-order strap
	input  wire logic write_width_sel,          // Write width strap
	input  wire logic read_width_sel,           // Read width strap
	input  wire logic parity_place_sel,         // Parity placement strap
	input  wire logic offset_access_sel,        // Offset method/preset strap
	input  wire logic default_offset_sel_lo,    // Preset select bit 0
	input  wire logic default_offset_sel_hi,    // Preset select bit 1
	frc_cfg_if.src    cfg_port                  // Configuration out
);

	frc_cfg_t cfg_r;
	frc_cfg_t cfg_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		if (!full_reset_n) begin
			cfg_nxt.fallthrough_mode    = fallthrough_or_serial_in;
			cfg_nxt.little_endian       = byte_order_sel;
			cfg_nxt.write_narrow        = write_width_sel;
			cfg_nxt.read_narrow         = read_width_sel;
			cfg_nxt.parity_interspersed = parity_place_sel;
			cfg_nxt.serial_method       = !offset_access_sel;
			cfg_nxt.default_idx         = {offset_access_sel, default_offset_sel_hi, default_offset_sel_lo};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfg_r <= CFG_RST;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	assign cfg_port.cfg    = cfg_r;
	assign cfg_port.in_rst = !full_reset_n;

	chk_strap_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!full_reset_n |=> cfg_r.fallthrough_mode == $past(fallthrough_or_serial_in)
			&& cfg_r.little_endian == $past(byte_order_sel) && cfg_r.write_narrow == $past(write_width_sel))
		else $error("straps not captured during full reset");
	chk_cfg_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		full_reset_n && $past(full_reset_n) |-> $stable(cfg_r))
		else $error("configuration changed after full reset");

endmodule // frc_cfg_capture

// ===== frc_fifo_top.sv
// Bus-matching FIFO core with reset-time configuration and status flags
`timescale 1ns/1ps
module frc_fifo_top
	import frc_pkg::*;
(
	input  wire logic              clk_sys,                  // System clock, 40 MHz
	input  wire logic              rst_n,                    // Sync reset, active low
	input  wire logic              full_reset_n,             // Full reset, active low
	input  wire logic              write_en,                 // Write strobe, active high
	input  wire logic [DATA_W-1:0] write_data_in,            // Write data
	input  wire logic              read_en,                  // Read strobe, active high
	input  wire logic              offset_access_sel,        // Offset register access
	input  wire logic              serial_shift_enable,      // Serial offset shift, active high
	input  wire logic              fallthrough_or_serial_in, // Mode strap / serial data
	input  wire logic              byte_order_sel,           // Byte-order strap
	input  wire logic              write_width_sel,          // Write width strap
	input  wire logic              read_width_sel,           // Read width strap
	input  wire logic              parity_place_sel,         // Parity placement strap
	input  wire logic              default_offset_sel_lo,    // Preset select bit 0
	input  wire logic              default_offset_sel_hi,    // Preset select bit 1
	output logic      [DATA_W-1:0] read_data_out,            // Output register
	output logic                   empty_or_valid_out,       // Empty / output-ready, low active
	output logic                   full_or_room_out,         // Full / input-ready, low active
	output logic                   half_level_flag,          // Above half, low active
	output logic                   almost_empty_flag,        // Below empty offset, low active
	output logic                   almost_full_flag          // Within full offset, low active
);

	frc_cfg_if cfg_bus ();

	frc_cfg_capture u_cfg (
		.clk_sys                  (clk_sys),
		.rst_n                    (rst_n),
		.full_reset_n             (full_reset_n),
		.fallthrough_or_serial_in (fallthrough_or_serial_in),
		.byte_order_sel           (byte_order_sel),
		.write_width_sel          (write_width_sel),
		.read_width_sel           (read_width_sel),
		.parity_place_sel         (parity_place_sel),
		.offset_access_sel        (offset_access_sel),
		.default_offset_sel_lo    (default_offset_sel_lo),
		.default_offset_sel_hi    (default_offset_sel_hi),
		.cfg_port                 (cfg_bus)
	);

	frc_cfg_t cfg;
	logic     in_rst;
	assign cfg    = cfg_bus.cfg;
	assign in_rst = cfg_bus.in_rst;

	logic [DATA_W-1:0] mem [DEPTH];

	logic [ADDR_W-1:0] wr_ptr_r;
	logic [ADDR_W-1:0] wr_ptr_nxt;
	logic [ADDR_W-1:0] rd_ptr_r;
	logic [ADDR_W-1:0] rd_ptr_nxt;
	logic [CNT_W-1:0]  count_r;
	logic [CNT_W-1:0]  count_nxt;
	logic              wr_half_r;
	logic              wr_half_nxt;
	logic [BYTE_W-1:0] wr_hold_r;
	logic [BYTE_W-1:0] wr_hold_nxt;
	logic              rd_half_r;
	logic              rd_half_nxt;
	logic [DATA_W-1:0] out_r;
	logic [DATA_W-1:0] out_nxt;
	logic              valid_r;
	logic              valid_nxt;
	logic [OFS_W-1:0]  empty_ofs_r;
	logic [OFS_W-1:0]  empty_ofs_nxt;
	logic [OFS_W-1:0]  full_ofs_r;
	logic [OFS_W-1:0]  full_ofs_nxt;
	frc_ofs_sel_t      ofs_wsel_r;
	frc_ofs_sel_t      ofs_wsel_nxt;
	frc_ofs_sel_t      ofs_rsel_r;
	frc_ofs_sel_t      ofs_rsel_nxt;

	logic              mem_full;
	logic              mem_empty;
	logic              data_wr;
	logic              data_rd;
	logic              accept;
	logic              push;
	logic              fetch;
	logic              pop;
	logic [DATA_W-1:0] wr_word;
	logic [DATA_W-1:0] head_word;
	logic [DATA_W-1:0] fetch_word;
	logic [OFS_W-1:0]  par_ofs;
	logic [CNT_W-1:0]  free_cnt;

	assign mem_full  = (count_r == DEPTH_CNT);
	assign mem_empty = (count_r == CNT_ZERO);
	assign data_wr   = write_en && !offset_access_sel;
	assign data_rd   = read_en && !offset_access_sel;
	assign accept    = data_wr && !mem_full;
	// Half-words never count as stored until the pair is complete
	assign push      = accept && (!cfg.write_narrow || wr_half_r);
	assign head_word = mem[rd_ptr_r];
	assign par_ofs   = frc_parallel_ofs(write_data_in, cfg.parity_interspersed, cfg.write_narrow);
	assign free_cnt  = DEPTH_CNT - count_r;

	// Narrow writes: the first byte lands in the upper half for big-endian
	always_comb begin
		wr_word = write_data_in;
		if (cfg.write_narrow) begin
			wr_word = cfg.little_endian ? {write_data_in[8:0], wr_hold_r}
				: {wr_hold_r, write_data_in[8:0]};
		end
	end

	// Fall-through keeps the output register primed without a read
	always_comb begin
		fetch = !mem_empty && (cfg.fallthrough_mode ? (!valid_r || data_rd) : data_rd);
		pop   = fetch && (!cfg.read_narrow || rd_half_r);
		fetch_word = head_word;
		if (cfg.read_narrow) begin
			fetch_word = {BYTE_ZERO, frc_pick_byte(head_word, cfg.little_endian ? rd_half_r : !rd_half_r)};
		end
	end

	always_comb begin
		wr_ptr_nxt    = wr_ptr_r;
		rd_ptr_nxt    = rd_ptr_r;
		count_nxt     = count_r;
		wr_half_nxt   = wr_half_r;
		wr_hold_nxt   = wr_hold_r;
		rd_half_nxt   = rd_half_r;
		out_nxt       = out_r;
		valid_nxt     = valid_r;
		empty_ofs_nxt = empty_ofs_r;
		full_ofs_nxt  = full_ofs_r;
		ofs_wsel_nxt  = ofs_wsel_r;
		ofs_rsel_nxt  = ofs_rsel_r;
		if (in_rst) begin
			wr_ptr_nxt    = PTR_ZERO;
			rd_ptr_nxt    = PTR_ZERO;
			out_nxt       = WORD_ZERO;
			count_nxt     = CNT_ZERO;
			wr_half_nxt   = 1'b0;
			rd_half_nxt   = 1'b0;
			valid_nxt     = 1'b0;
			ofs_wsel_nxt  = FRC_OFS_EMPTY;
			ofs_rsel_nxt  = FRC_OFS_EMPTY;
			// Lags the strap latch by one cycle, so reset must last two
			empty_ofs_nxt = frc_default_ofs(cfg.default_idx);
			full_ofs_nxt  = frc_default_ofs(cfg.default_idx);
		end else begin
			if (accept) begin
				wr_half_nxt = cfg.write_narrow && !wr_half_r;
				wr_hold_nxt = write_data_in[8:0];
			end
			if (push) begin
				wr_ptr_nxt = wr_ptr_r + PTR_ONE;
			end
			if (fetch) begin
				out_nxt     = fetch_word;
				valid_nxt   = cfg.fallthrough_mode;
				rd_half_nxt = cfg.read_narrow && !rd_half_r;
			end else if (data_rd) begin
				valid_nxt = 1'b0;
			end
			if (pop) begin
				rd_ptr_nxt = rd_ptr_r + PTR_ONE;
			end
			count_nxt = count_r + (push ? CNT_ONE : CNT_ZERO) - (pop ? CNT_ONE : CNT_ZERO);
			if (write_en && offset_access_sel && !cfg.serial_method) begin
				if (ofs_wsel_r == FRC_OFS_EMPTY) begin
					empty_ofs_nxt = par_ofs;
				end else begin
					full_ofs_nxt = par_ofs;
				end
				ofs_wsel_nxt = (ofs_wsel_r == FRC_OFS_EMPTY) ? FRC_OFS_FULL : FRC_OFS_EMPTY;
			end else if (serial_shift_enable && offset_access_sel && cfg.serial_method) begin
				{empty_ofs_nxt, full_ofs_nxt} = {empty_ofs_r[7:0], full_ofs_r, fallthrough_or_serial_in};
			end
			if (read_en && offset_access_sel) begin
				out_nxt      = {BYTE_ZERO, (ofs_rsel_r == FRC_OFS_EMPTY) ? empty_ofs_r : full_ofs_r};
				ofs_rsel_nxt = (ofs_rsel_r == FRC_OFS_EMPTY) ? FRC_OFS_FULL : FRC_OFS_EMPTY;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_r] <= wr_word;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr_ptr_r    <= PTR_ZERO;
			rd_ptr_r    <= PTR_ZERO;
			count_r     <= CNT_ZERO;
			wr_half_r   <= 1'b0;
			wr_hold_r   <= BYTE_ZERO;
			rd_half_r   <= 1'b0;
			out_r       <= WORD_ZERO;
			valid_r     <= 1'b0;
			empty_ofs_r <= OFS_RST;
			full_ofs_r  <= OFS_RST;
			ofs_wsel_r  <= FRC_OFS_EMPTY;
			ofs_rsel_r  <= FRC_OFS_EMPTY;
		end else begin
			wr_ptr_r    <= wr_ptr_nxt;
			rd_ptr_r    <= rd_ptr_nxt;
			count_r     <= count_nxt;
			wr_half_r   <= wr_half_nxt;
			wr_hold_r   <= wr_hold_nxt;
			rd_half_r   <= rd_half_nxt;
			out_r       <= out_nxt;
			valid_r     <= valid_nxt;
			empty_ofs_r <= empty_ofs_nxt;
			full_ofs_r  <= full_ofs_nxt;
			ofs_wsel_r  <= ofs_wsel_nxt;
			ofs_rsel_r  <= ofs_rsel_nxt;
		end
	end

	assign read_data_out      = out_r;
	assign empty_or_valid_out = cfg.fallthrough_mode ? !valid_r : !mem_empty;
	assign full_or_room_out   = cfg.fallthrough_mode ? mem_full : !mem_full;
	assign half_level_flag    = !(count_r > HALF_LEVEL);
	assign almost_empty_flag  = (count_r >= {1'b0, empty_ofs_r});
	assign almost_full_flag   = !(free_cnt <= {1'b0, full_ofs_r});

	chk_reset_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!full_reset_n |=> wr_ptr_r == PTR_ZERO && rd_ptr_r == PTR_ZERO && read_data_out == WORD_ZERO)
		else $error("full reset did not clear pointers and output");
	chk_empty_std: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cfg.fallthrough_mode |-> (empty_or_valid_out == (count_r != CNT_ZERO)))
		else $error("standard empty flag wrong");
	chk_ready_fallthrough_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg.fallthrough_mode && full_reset_n && !mem_empty && !valid_r |=> !empty_or_valid_out)
		else $error("output ready not asserted after fall-through fetch");
	chk_full_std: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cfg.fallthrough_mode |-> (full_or_room_out == (count_r != DEPTH_CNT)))
		else $error("standard full flag wrong");
	chk_room_fallthrough_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg.fallthrough_mode |-> (full_or_room_out == (count_r == DEPTH_CNT)))
		else $error("input ready flag wrong");
	chk_half_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		half_level_flag == (count_r <= HALF_LEVEL))
		else $error("half level flag wrong");
	chk_wide_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		full_reset_n && !cfg.write_narrow && push |=> mem[$past(wr_ptr_r)] == $past(write_data_in))
		else $error("wide write not stored unaltered");
	chk_offset_steer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		full_reset_n && offset_access_sel |=> count_r == $past(count_r) || $past(pop))
		else $error("offset access disturbed stored count");
	chk_serial_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
		full_reset_n && cfg.serial_method && offset_access_sel && serial_shift_enable && !write_en
			|=> full_ofs_r[0] == $past(fallthrough_or_serial_in))
		else $error("serial bit not shifted in");

endmodule // frc_fifo_top

// ===== frc_far_model.sv
// Producer and consumer model driving the write, read, offset and strap pins
`timescale 1ns/1ps
module frc_far_model
	import frc_pkg::*;
(
	input  wire logic              clk_sys,                  // System clock
	input  wire logic [DATA_W-1:0] read_data_out,            // Output register
	output logic                   full_reset_n,             // Full reset, active low
	output logic                   write_en,                 // Write strobe
	output logic      [DATA_W-1:0] write_data_in,            // Write data
	output logic                   read_en,                  // Read strobe
	output logic                   offset_access_sel,        // Offset access / strap
	output logic                   serial_shift_enable,      // Serial shift strobe
	output logic                   fallthrough_or_serial_in, // Mode strap / serial bit
	output logic                   byte_order_sel,           // Byte-order strap
	output logic                   write_width_sel,          // Write width strap
	output logic                   read_width_sel,           // Read width strap
	output logic                   parity_place_sel,         // Parity strap
	output logic                   default_offset_sel_lo,    // Preset bit 0
	output logic                   default_offset_sel_hi     // Preset bit 1
);
	initial begin
		{full_reset_n, write_en, read_en, offset_access_sel, serial_shift_enable} = 5'h00;
		{fallthrough_or_serial_in, byte_order_sel, write_width_sel, read_width_sel} = 4'h0;
		{parity_place_sel, default_offset_sel_lo, default_offset_sel_hi} = 3'h0;
		write_data_in = WORD_ZERO;
	end

	// Straps move only inside a full reset; afterwards only offset_access_sel and fallthrough_or_serial_in move
	task automatic reset_dev(input logic [7:0] s);
		@(posedge clk_sys);
		full_reset_n <= 1'b0;
		{fallthrough_or_serial_in, byte_order_sel, write_width_sel, read_width_sel, parity_place_sel,
			offset_access_sel, default_offset_sel_hi, default_offset_sel_lo} <= s;
		repeat (2) @(posedge clk_sys);
		full_reset_n      <= 1'b1;
		offset_access_sel <= 1'b0;
	endtask

	task automatic wr(input logic ofs, input logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		write_en          <= 1'b1;
		offset_access_sel <= ofs;
		write_data_in     <= write_width_sel ? {9'h000, d[8:0]} : d;
		@(posedge clk_sys);
		write_en          <= 1'b0;
		offset_access_sel <= 1'b0;
		// Idle bus toggles so a stale word is never mistaken for data
		write_data_in     <= write_width_sel ? {9'h000, ~write_data_in[8:0]} : ~write_data_in;
	endtask

	task automatic rd(input logic ofs, output logic [DATA_W-1:0] q);
		@(posedge clk_sys);
		read_en           <= 1'b1;
		offset_access_sel <= ofs;
		@(posedge clk_sys);
		read_en           <= 1'b0;
		offset_access_sel <= 1'b0;
		@(posedge clk_sys);
		#1;
		q = read_data_out;
	endtask

	task automatic shift(input logic b);
		@(posedge clk_sys);
		serial_shift_enable      <= 1'b1;
		offset_access_sel        <= 1'b1;
		fallthrough_or_serial_in <= b;
		@(posedge clk_sys);
		serial_shift_enable      <= 1'b0;
		offset_access_sel        <= 1'b0;
	endtask
endmodule // frc_far_model

// ===== frc_fifo_top_tb.sv
// Self-checking bench for reset configuration and status flags of the FIFO
`timescale 1ns/1ps
module frc_fifo_top_tb
	import frc_pkg::*;
;
	logic              clk_sys, rst_n, full_reset_n, write_en, read_en, offset_access_sel, serial_shift_enable;
	logic              fallthrough_or_serial_in, byte_order_sel, write_width_sel, read_width_sel;
	logic              parity_place_sel, default_offset_sel_lo, default_offset_sel_hi;
	logic              empty_or_valid_out, full_or_room_out, half_level_flag, almost_empty_flag, almost_full_flag;
	logic [DATA_W-1:0] write_data_in, read_data_out, q;
	logic [DATA_W-1:0] pat;
	int                mismatches, check_count, cycles;
	logic [OFS_W-1:0]  presets [8] = '{OFS_PRESET0, OFS_PRESET1, OFS_PRESET2, OFS_PRESET3,
		OFS_PRESET4, OFS_PRESET5, OFS_PRESET6, OFS_PRESET7};

	frc_fifo_top dut (.clk_sys, .rst_n, .full_reset_n, .write_en, .write_data_in, .read_en, .offset_access_sel,
		.serial_shift_enable, .fallthrough_or_serial_in, .byte_order_sel, .write_width_sel, .read_width_sel,
		.parity_place_sel, .default_offset_sel_lo, .default_offset_sel_hi, .read_data_out, .empty_or_valid_out,
		.full_or_room_out, .half_level_flag, .almost_empty_flag, .almost_full_flag);

	frc_far_model u_far (.clk_sys, .read_data_out, .full_reset_n, .write_en, .write_data_in, .read_en,
		.offset_access_sel, .serial_shift_enable, .fallthrough_or_serial_in, .byte_order_sel, .write_width_sel,
		.read_width_sel, .parity_place_sel, .default_offset_sel_lo, .default_offset_sel_hi);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		if (mismatches == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Straps vector order: fall-through, byte order, write width, read width, parity, offset access, sel hi, sel lo
	task automatic t_reset_clear();
		u_far.reset_dev(8'h00);
		u_far.wr(1'b0, 18'h3ffff);
		u_far.wr(1'b0, 18'h12345);
		u_far.rd(1'b0, q);
		check("first word", q, 18'h3ffff);
		u_far.reset_dev(8'h00);
		#1;
		check("output after reset", read_data_out, WORD_ZERO);
		check("empty flag", empty_or_valid_out, 1'b0);
		check("full flag", full_or_room_out, 1'b1);
		check("half flag", half_level_flag, 1'b1);
		u_far.wr(1'b0, 18'h00001);
		#1;
		check("empty flag after write", empty_or_valid_out, 1'b1);
	endtask

	// Fill past capacity with parity interspersed; the surplus write must vanish
	task automatic t_fill();
		u_far.reset_dev(8'h08);
		for (int i = 1; i <= DEPTH + 1; i++) begin
			u_far.wr(1'b0, 18'(i * 515) ^ 18'h2aaaa);
			#1;
			if (i == 256 || i == 257) check("half flag", half_level_flag, i == 256);
		end
		check("full flag", full_or_room_out, 1'b0);
		check("almost full", almost_full_flag, 1'b0);
		for (int i = 1; i <= DEPTH; i++) begin
			u_far.rd(1'b0, q);
			check("stored word", q, 18'(i * 515) ^ 18'h2aaaa);
		end
		check("empty after drain", empty_or_valid_out, 1'b0);
		check("almost empty", almost_empty_flag, 1'b0);
	endtask

	task automatic t_fallthrough();
		u_far.reset_dev(8'h80);
		#1;
		check("no word ready", empty_or_valid_out, 1'b1);
		check("room", full_or_room_out, 1'b0);
		u_far.wr(1'b0, 18'h1b2c4);
		repeat (2) @(posedge clk_sys);
		#1;
		check("word ready", empty_or_valid_out, 1'b0);
		check("word shown", read_data_out, 18'h1b2c4);
		u_far.rd(1'b0, q);
		check("ready cleared", empty_or_valid_out, 1'b1);
	endtask

	task automatic t_bus_match();
		for (int be = 0; be < 2; be++) begin
			u_far.reset_dev({1'b0, 1'(be), 6'h10});
			u_far.wr(1'b0, 18'h2a5c3);
			u_far.rd(1'b0, q);
			check("first byte", q, be ? 18'h001c3 : 18'h00152);
			u_far.rd(1'b0, q);
			check("second byte", q, be ? 18'h00152 : 18'h001c3);
			u_far.reset_dev({1'b0, 1'(be), 6'h20});
			u_far.wr(1'b0, 18'h0019a);
			u_far.wr(1'b0, 18'h00065);
			u_far.rd(1'b0, q);
			check("joined word", q, be ? 18'h0cb9a : 18'h33465);
		end
	endtask

	task automatic t_presets();
		for (int k = 0; k < 8; k++) begin
			u_far.reset_dev({5'h00, 3'(k)});
			#1;
			check("almost empty at reset", almost_empty_flag, 1'b0);
			u_far.rd(1'b1, q);
			check("empty preset", q, {9'h000, presets[k]});
			u_far.rd(1'b1, q);
			check("full preset", q, {9'h000, presets[k]});
		end
	endtask

	// Bit 8 and bit 9 differ so the parity slot shows in the loaded value
	task automatic t_offset_load();
		for (int ip = 0; ip < 2; ip++) begin
			u_far.reset_dev({4'h0, 1'(ip), 3'h4});
			u_far.wr(1'b1, 18'h302a5);
			u_far.wr(1'b1, 18'h0015a);
			#1;
			check("memory untouched", empty_or_valid_out, 1'b0);
			u_far.rd(1'b1, q);
			check("parallel empty offset", q, ip ? 18'h001a5 : 18'h000a5);
			u_far.rd(1'b1, q);
			check("parallel full offset", q, ip ? 18'h0005a : 18'h0015a);
		end
		pat = 18'h2d3b4;
		u_far.reset_dev(8'h00);
		for (int b = 17; b >= 0; b--) u_far.shift(pat[b]);
		#1;
		check("mode kept", empty_or_valid_out, 1'b0);
		u_far.rd(1'b1, q);
		check("serial empty offset", q, {9'h000, pat[17:9]});
		u_far.rd(1'b1, q);
		check("serial full offset", q, {9'h000, pat[8:0]});
	endtask

	initial begin
		rst_n = 1'b0;
		mismatches = 0;
		check_count = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset_clear();
		t_fill();
		t_fallthrough();
		t_bus_match();
		t_presets();
		t_offset_load();
		test_done();
	end

	// Whole run needs about 2800 cycles
	initial cycles = 0;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
endmodule // frc_fifo_top_tb
